// ==== design/pio_port_io.sv ====
// Port I/O block: three 8-bit ports, priority crossbar, port match on ports 0 and 1.
// Assumes a single-cycle register port from the core and pins resolved outside from
// the output/enable pairs.
`timescale 1ns/1ns
`default_nettype none
module pio_port_io
   import pio_pkg::*;
#(
   parameter int NUM_PERIPH = 16
) (
   input  wire logic                  SYS_CLK_IN,
   input  wire logic                  RST_B_IN,
   input  wire logic [7:0]            SFR_ADDR_IN,
   input  wire logic                  SFR_WR_IN,
   input  wire logic [7:0]            SFR_WDATA_IN,
   output var  logic [7:0]            SFR_RDATA_OUT,
   input  wire logic [23:0]           PIN_IN,
   output var  logic [23:0]           PIN_OUT,
   output var  logic [23:0]           PIN_OE_OUT,
   output var  logic [23:0]           PIN_DRIVE_HIGH_OUT,
   output var  logic [23:0]           PIN_ANALOG_OUT,
   input  wire logic [NUM_PERIPH-1:0] PERIPH_DATA_IN,
   input  wire logic [NUM_PERIPH-1:0] PERIPH_OE_IN,
   output var  logic [NUM_PERIPH-1:0] PERIPH_PIN_LEVEL_OUT,
   output var  logic [NUM_PERIPH-1:0] PERIPH_ROUTED_OUT,
   output var  logic                  PORT_MISMATCH_OUT
);

   localparam int NPINS = NUM_PORTS * 8;

   if (NUM_PERIPH < 1 || NUM_PERIPH > 16) begin : g_bad_periph
      $error("pio_port_io: NUM_PERIPH must be 1..16 (two 8-bit select registers)");
   end

   // -------------------------------------------------------------------------
   // Configuration registers
   // -------------------------------------------------------------------------
   logic [NUM_PORTS-1:0][7:0] latch_reg;
   logic [NUM_PORTS-1:0][7:0] mdout_reg;
   logic [NUM_PORTS-1:0][7:0] drive_reg;
   logic [NUM_PORTS-1:0][7:0] skip_reg;
   logic [NUM_PORTS-1:0][7:0] inmode_reg;
   logic [7:0]                xbar_low_reg;
   logic [7:0]                xbar_high_reg;
   logic [1:0][7:0]           match_reg;
   logic [1:0][7:0]           mask_reg;
   logic [NPINS-1:0]          pin_level;

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         for (int n = 0; n < NUM_PORTS; n++) begin
            latch_reg[n]  <= PIO_RST_LATCH;
            mdout_reg[n]  <= PIO_RST_MDOUT;
            drive_reg[n]  <= PIO_RST_DRIVE;
            skip_reg[n]   <= PIO_RST_SKIP;
            inmode_reg[n] <= PIO_RST_INMODE;
         end
      end else if (SFR_WR_IN) begin
         for (int n = 0; n < NUM_PORTS; n++) begin
            if (SFR_ADDR_IN == PIO_ADDR_LATCH[n]) begin
               latch_reg[n] <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == PIO_ADDR_MDOUT[n]) begin
               mdout_reg[n] <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == PIO_ADDR_DRIVE[n]) begin
               drive_reg[n] <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == PIO_ADDR_SKIP[n]) begin
               skip_reg[n] <= SFR_WDATA_IN;
            end
            if (SFR_ADDR_IN == PIO_ADDR_INMODE[n]) begin
               inmode_reg[n] <= SFR_WDATA_IN;
            end
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         xbar_low_reg  <= PIO_RST_XBAR;
         xbar_high_reg <= PIO_RST_XBAR;
         match_reg[0]  <= PIO_RST_MATCH;
         match_reg[1]  <= PIO_RST_MATCH;
         mask_reg[0]   <= PIO_RST_MASK;
         mask_reg[1]   <= PIO_RST_MASK;
      end else if (SFR_WR_IN) begin
         unique case (SFR_ADDR_IN)
            PIO_ADDR_XBAR_LOW:  xbar_low_reg  <= SFR_WDATA_IN;
            PIO_ADDR_XBAR_HIGH: xbar_high_reg <= SFR_WDATA_IN;
            PIO_ADDR_P0_MATCH:  match_reg[0]  <= SFR_WDATA_IN;
            PIO_ADDR_P1_MATCH:  match_reg[1]  <= SFR_WDATA_IN;
            PIO_ADDR_P0_MASK:   mask_reg[0]   <= SFR_WDATA_IN;
            PIO_ADDR_P1_MASK:   mask_reg[1]   <= SFR_WDATA_IN;
            default: ;
         endcase
      end
   end

   // -------------------------------------------------------------------------
   // Read path
   // -------------------------------------------------------------------------
   logic [7:0] rdata_next;

   always_comb begin
      rdata_next = PIO_RST_RDATA;
      for (int n = 0; n < NUM_PORTS; n++) begin
         // Latch address reads the pins, not the latch, whatever the crossbar does
         if (SFR_ADDR_IN == PIO_ADDR_LATCH[n])  rdata_next = pin_level[n*8 +: 8];
         if (SFR_ADDR_IN == PIO_ADDR_MDOUT[n])  rdata_next = mdout_reg[n];
         if (SFR_ADDR_IN == PIO_ADDR_DRIVE[n])  rdata_next = drive_reg[n];
         if (SFR_ADDR_IN == PIO_ADDR_SKIP[n])   rdata_next = skip_reg[n];
         if (SFR_ADDR_IN == PIO_ADDR_INMODE[n]) rdata_next = inmode_reg[n];
      end
      if (SFR_ADDR_IN == PIO_ADDR_XBAR_LOW)  rdata_next = xbar_low_reg;
      if (SFR_ADDR_IN == PIO_ADDR_XBAR_HIGH) rdata_next = xbar_high_reg;
      if (SFR_ADDR_IN == PIO_ADDR_P0_MATCH)  rdata_next = match_reg[0];
      if (SFR_ADDR_IN == PIO_ADDR_P1_MATCH)  rdata_next = match_reg[1];
      if (SFR_ADDR_IN == PIO_ADDR_P0_MASK)   rdata_next = mask_reg[0];
      if (SFR_ADDR_IN == PIO_ADDR_P1_MASK)   rdata_next = mask_reg[1];
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         SFR_RDATA_OUT <= PIO_RST_RDATA;
      end else begin
         SFR_RDATA_OUT <= rdata_next;
      end
   end

   // -------------------------------------------------------------------------
   // Pin input synchronisation
   // -------------------------------------------------------------------------
   pio_pin_sync #(
      .WIDTH          (NPINS)
   ) u_sync (
      .clk_in         (SYS_CLK_IN),
      .rst_b_in       (RST_B_IN),
      .async_in       (PIN_IN),
      .reset_level_in ('0),
      .level_out      (pin_level)
   );

   // -------------------------------------------------------------------------
   // Priority crossbar
   // -------------------------------------------------------------------------
   // Walks pins from port 0 bit 0 upward, handing each free pin to the lowest
   // numbered enabled peripheral not yet placed. A full-width search per pin is
   // deep logic, traded for a compact description at 10 MHz.
   logic [15:0]           xbar_en;
   logic [NPINS-1:0]      pin_routed;
   logic [NPINS-1:0][3:0] pin_periph;
   logic [NPINS-1:0]      skip_flat;

   assign xbar_en   = {xbar_high_reg, xbar_low_reg};
   assign skip_flat = skip_reg;

   always_comb begin
      int  ptr;
      logic found;
      ptr   = 0;
      found = 1'b0;
      for (int p = 0; p < NPINS; p++) begin
         pin_routed[p] = 1'b0;
         pin_periph[p] = 4'h0;
         if (!skip_flat[p]) begin
            found = 1'b0;
            for (int k = 0; k < NUM_PERIPH; k++) begin
               if (!found && k >= ptr && xbar_en[k]) begin
                  found         = 1'b1;
                  pin_routed[p] = 1'b1;
                  pin_periph[p] = 4'(k);
               end
            end
            if (found) begin
               ptr = int'(pin_periph[p]) + 1;
            end
         end
      end
   end

   // -------------------------------------------------------------------------
   // Output drivers and peripheral return path
   // -------------------------------------------------------------------------
   logic [NPINS-1:0]      out_next;
   logic [NPINS-1:0]      oe_next;
   logic [NPINS-1:0]      mdout_flat;
   logic [NPINS-1:0]      latch_flat;
   logic [NPINS-1:0]      digital_flat;
   logic [NUM_PERIPH-1:0] plevel_next;
   logic [NUM_PERIPH-1:0] routed_next;

   assign mdout_flat   = mdout_reg;
   assign latch_flat   = latch_reg;
   assign digital_flat = inmode_reg;

   always_comb begin
      logic val;
      logic want_oe;
      val         = 1'b0;
      want_oe     = 1'b0;
      plevel_next = '0;
      routed_next = '0;
      for (int p = 0; p < NPINS; p++) begin
         if (pin_routed[p]) begin
            val     = PERIPH_DATA_IN[pin_periph[p]];
            want_oe = PERIPH_OE_IN[pin_periph[p]];
            plevel_next[pin_periph[p]] = pin_level[p];
            routed_next[pin_periph[p]] = 1'b1;
         end else begin
            val     = latch_flat[p];
            want_oe = 1'b1;
         end
         if (!digital_flat[p]) begin
            // Analog pin: driver off so the analog path sees the pad
            out_next[p] = 1'b0;
            oe_next[p]  = 1'b0;
         end else if (mdout_flat[p]) begin
            out_next[p] = val;
            oe_next[p]  = want_oe;
         end else begin
            // Open-drain only pulls low; a one releases the pin
            out_next[p] = 1'b0;
            oe_next[p]  = want_oe & ~val;
         end
      end
   end

   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         PIN_OUT              <= '0;
         PIN_OE_OUT           <= '0;
         PIN_DRIVE_HIGH_OUT   <= '0;
         PIN_ANALOG_OUT       <= '0;
         PERIPH_PIN_LEVEL_OUT <= '0;
         PERIPH_ROUTED_OUT    <= '0;
      end else begin
         PIN_OUT              <= out_next;
         PIN_OE_OUT           <= oe_next;
         PIN_DRIVE_HIGH_OUT   <= drive_reg;
         PIN_ANALOG_OUT       <= ~digital_flat;
         PERIPH_PIN_LEVEL_OUT <= plevel_next;
         PERIPH_ROUTED_OUT    <= routed_next;
      end
   end

   // -------------------------------------------------------------------------
   // Port match
   // -------------------------------------------------------------------------
   // Uses synchronised pad levels, so a crossbar-driven pin still takes part
   logic mismatch_next;

   assign mismatch_next =
      ((pin_level[7:0]  & mask_reg[0]) != (match_reg[0] & mask_reg[0])) ||
      ((pin_level[15:8] & mask_reg[1]) != (match_reg[1] & mask_reg[1]));

   // Level feeds both the interrupt controller and the wake logic
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         PORT_MISMATCH_OUT <= 1'b0;
      end else begin
         PORT_MISMATCH_OUT <= mismatch_next;
      end
   end

endmodule
`default_nettype wire

// ==== design/pio_pkg.sv ====
// Constants for the port I/O, crossbar and port-match block.
// Assumes an 8-bit special function register port driven by the processor core.
//
// Functional notes
// - Every pin: GPIO, peripheral, or analog
// - Port latch read returns pin levels
// - Crossbar assigns enabled peripherals by priority
// - Output mode bit selects push-pull/open-drain
// - Drive strength selectable, low after reset
// - Skip bit keeps crossbar off pin
// - Mismatch when masked pins differ from match
// - Compare actual pin levels against match registers
// - Mismatch usable as interrupt and wake
// - Port 0 mask resets zero, 1 compares; here the port 1 mask also resets to zero
`default_nettype none
package pio_pkg;

   localparam int NUM_PORTS = 3;

   // -------------------------------------------------------------------------
   // Register addresses
   // -------------------------------------------------------------------------
   localparam logic [7:0] PIO_ADDR_XBAR_LOW   = 8'hE1;
   localparam logic [7:0] PIO_ADDR_XBAR_HIGH  = 8'hE2;
   localparam logic [7:0] PIO_ADDR_P0_MASK    = 8'hF4;
   localparam logic [7:0] PIO_ADDR_P1_MASK    = 8'hD9;
   localparam logic [7:0] PIO_ADDR_P0_MATCH   = 8'hD7;
   localparam logic [7:0] PIO_ADDR_P1_MATCH   = 8'hD8;

   typedef logic [NUM_PORTS-1:0][7:0] pio_addr_tbl_t;

   // Index 0 is port 0
   localparam pio_addr_tbl_t PIO_ADDR_LATCH  = {8'hA0, 8'h90, 8'h80};
   localparam pio_addr_tbl_t PIO_ADDR_MDOUT  = {8'hA6, 8'hA5, 8'hA4};
   localparam pio_addr_tbl_t PIO_ADDR_DRIVE  = {8'hFB, 8'hFA, 8'hF9};
   localparam pio_addr_tbl_t PIO_ADDR_SKIP   = {8'hD6, 8'hD5, 8'hD4};
   localparam pio_addr_tbl_t PIO_ADDR_INMODE = {8'hF3, 8'hF2, 8'hF1};

   // -------------------------------------------------------------------------
   // Reset values
   // -------------------------------------------------------------------------
   localparam logic [7:0] PIO_RST_LATCH  = 8'hFF;
   localparam logic [7:0] PIO_RST_MDOUT  = 8'h00;
   localparam logic [7:0] PIO_RST_DRIVE  = 8'h00;
   localparam logic [7:0] PIO_RST_SKIP   = 8'h00;
   localparam logic [7:0] PIO_RST_INMODE = 8'hFF;
   localparam logic [7:0] PIO_RST_XBAR   = 8'h00;
   localparam logic [7:0] PIO_RST_MATCH  = 8'h00;
   localparam logic [7:0] PIO_RST_MASK   = 8'h00;
   localparam logic [7:0] PIO_RST_RDATA  = 8'h00;

endpackage
`default_nettype wire

// ==== design/pio_pin_sync.sv ====
// Three-stage input synchroniser with agreement filter.
// Assumes asynchronous pin levels; output changes only when stages two and three agree.
`timescale 1ns/1ns
`default_nettype none
module pio_pin_sync
   import pio_pkg::*;
#(
   parameter int WIDTH = 24
) (
   input  wire logic             clk_in,
   input  wire logic             rst_b_in,
   input  wire logic [WIDTH-1:0] async_in,
   input  wire logic [WIDTH-1:0] reset_level_in,
   output var  logic [WIDTH-1:0] level_out
);

   if (WIDTH < 1) begin : g_bad_width
      $error("pio_pin_sync: WIDTH must be at least 1");
   end

   genvar b;
   for (b = 0; b < WIDTH; b++) begin : g_bit
      logic s1_reg;
      logic s2_reg;
      logic s3_reg;
      // First stage feeds only the second stage
      always_ff @(posedge clk_in) begin
         if (!rst_b_in) begin
            s1_reg       <= reset_level_in[b];
            s2_reg       <= reset_level_in[b];
            s3_reg       <= reset_level_in[b];
            level_out[b] <= reset_level_in[b];
         end else begin
            s1_reg <= async_in[b];
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            if (s2_reg == s3_reg) begin
               level_out[b] <= s3_reg;
            end
         end
      end
   end

endmodule
`default_nettype wire

// ==== dv/pio_pin_model.sv ====
// External circuits on the 24 port pins: pull-ups plus an optional outside driver.
// Assumes the bench resolves nothing itself; this model feeds PIN_IN.
`timescale 1ns/1ns
`default_nettype none
module pio_pin_model (
   input  wire logic [23:0] pin_out_in,
   input  wire logic [23:0] pin_oe_in,
   input  wire logic [23:0] ext_en_in,
   input  wire logic [23:0] ext_val_in,
   output var  logic [23:0] pin_level_out
);
   // --------------------------------------------------------------------------
   // Wired-AND with pull-up
   // --------------------------------------------------------------------------
   // Released pins float high through the pull-up, never hold their last value
   assign pin_level_out = (~pin_oe_in | pin_out_in) & (~ext_en_in | ext_val_in);
endmodule
`default_nettype wire

// ==== dv/pio_port_io_properties.sv ====
// Port-level checker for the port I/O block.
// Assumes the register map of pio_pkg; shadows registers from observed writes.
`timescale 1ns/1ns
`default_nettype none
module pio_port_io_checker
   import pio_pkg::*;
#(
   parameter int NUM_PERIPH = 16
) (
   input wire logic                  SYS_CLK_IN,
   input wire logic                  RST_B_IN,
   input wire logic [7:0]            SFR_ADDR_IN,
   input wire logic                  SFR_WR_IN,
   input wire logic [7:0]            SFR_WDATA_IN,
   input wire logic [7:0]            SFR_RDATA_OUT,
   input wire logic [23:0]           PIN_IN,
   input wire logic [23:0]           PIN_OUT,
   input wire logic [23:0]           PIN_OE_OUT,
   input wire logic [23:0]           PIN_DRIVE_HIGH_OUT,
   input wire logic [23:0]           PIN_ANALOG_OUT,
   input wire logic [NUM_PERIPH-1:0] PERIPH_PIN_LEVEL_OUT,
   input wire logic [NUM_PERIPH-1:0] PERIPH_ROUTED_OUT,
   input wire logic                  PORT_MISMATCH_OUT
);
   // --------------------------------------------------------------------------
   // Register shadows
   // --------------------------------------------------------------------------
   logic [7:0]  sh [0:255];
   logic [23:0] mode_w;
   logic [23:0] skip_w;
   logic        miss_w;
   always_ff @(posedge SYS_CLK_IN) begin
      if (!RST_B_IN) begin
         for (int a = 0; a < 256; a++) begin
            sh[a] <= (a >= 8'hF1 && a <= 8'hF3) ? 8'hFF : 8'h00;
         end
      end else if (SFR_WR_IN) begin
         sh[SFR_ADDR_IN] <= SFR_WDATA_IN;
      end
   end
   assign mode_w = {sh[8'hA6], sh[8'hA5], sh[8'hA4]};
   assign skip_w = {sh[8'hD6], sh[8'hD5], sh[8'hD4]};
   assign miss_w = |((PIN_IN[7:0] ^ sh[8'hD7]) & sh[8'hF4])
                 | |((PIN_IN[15:8] ^ sh[8'hD8]) & sh[8'hD9]);
   default clocking @(posedge SYS_CLK_IN); endclocking
   default disable iff (!RST_B_IN);
   // --------------------------------------------------------------------------
   // Assertions
   // --------------------------------------------------------------------------
   reset_outputs_low_a: assert property (disable iff (1'b0) !RST_B_IN |=>
      PORT_MISMATCH_OUT == 1'b0 && PIN_DRIVE_HIGH_OUT == 24'h00_0000 && PIN_OE_OUT == 24'h00_0000)
      else $error("outputs not low after reset");
   mask_readback_a: assert property (SFR_WR_IN && SFR_ADDR_IN == 8'hF4 ##1
      SFR_ADDR_IN == 8'hF4 |=> SFR_RDATA_OUT == $past(SFR_WDATA_IN, 2))
      else $error("mask readback wrong");
   unmapped_read_zero_a: assert property (SFR_ADDR_IN == 8'h00 |=>
      SFR_RDATA_OUT == 8'h00) else $error("unmapped read not zero");
   latch_reads_pins_a: assert property ((SFR_ADDR_IN == 8'h80 &&
      $stable(PIN_IN[7:0]))[*8] |-> SFR_RDATA_OUT == PIN_IN[7:0])
      else $error("latch read differs from pins");
   mismatch_level_a: assert property ((!SFR_WR_IN && $stable(PIN_IN[15:0]))[*6]
      |-> PORT_MISMATCH_OUT == miss_w) else $error("mismatch level wrong");
   analog_mode_a: assert property ((!SFR_WR_IN)[*3] |-> PIN_ANALOG_OUT ==
      ~{sh[8'hF3], sh[8'hF2], sh[8'hF1]} && (PIN_ANALOG_OUT & PIN_OE_OUT) == 24'h00_0000)
      else $error("analog pin mode wrong");
   open_drain_low_a: assert property ((!SFR_WR_IN)[*3] |->
      (PIN_OUT & ~mode_w) == 24'h00_0000) else $error("open-drain pin drives high");
   drive_strength_a: assert property ((!SFR_WR_IN)[*3] |-> PIN_DRIVE_HIGH_OUT ==
      {sh[8'hFB], sh[8'hFA], sh[8'hF9]}) else $error("drive strength wrong");
   skip_blocks_xbar_a: assert property ((!SFR_WR_IN)[*3] ##0 skip_w == 24'hFF_FFFF
      |-> PERIPH_ROUTED_OUT == '0) else $error("peripheral routed to skipped pin");
   priority_route_a: assert property ((!SFR_WR_IN)[*3] ##0 skip_w == 24'h00_0000
      |-> PERIPH_ROUTED_OUT == NUM_PERIPH'({sh[8'hE2], sh[8'hE1]}))
      else $error("routed set differs from enables");
   cover property (PORT_MISMATCH_OUT);
   cover property (|PERIPH_ROUTED_OUT);
   cover property (|PIN_ANALOG_OUT);
endmodule
bind pio_port_io pio_port_io_checker #(.NUM_PERIPH(NUM_PERIPH)) u_chk (.*);
`default_nettype wire

// ==== dv/pio_port_io_bench.sv ====
// Self-checking bench for the port I/O block.
// Assumes pio_pin_model resolves the pins and the checker is bound to the design.
`timescale 1ns/1ns
`default_nettype none
`define CHECK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
   $display("mismatch t=%0t got=%h exp=%h", $time, got, exp); end end
module pio_port_io_bench;
   import pio_pkg::*;
   logic        sys_clk = 1'b0;
   logic        rst_b = 1'b0;
   logic        wr = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic [7:0]  wdata = 8'h00;
   logic [7:0]  rdata;
   logic [23:0] lvl, pout, poe, drv, ana;
   logic [23:0] ext_en = 24'h00_0000;
   logic [23:0] ext_val = 24'h00_0000;
   logic [15:0] pd = 16'h0000;
   logic [15:0] pde = 16'h0000;
   logic [15:0] plvl, routed;
   logic        miss;
   int          miscompares = 0;
   int          total_checks = 0;
   always #50 sys_clk = ~sys_clk;
   pio_port_io DUT (.SYS_CLK_IN(sys_clk), .RST_B_IN(rst_b), .SFR_ADDR_IN(addr), .SFR_WR_IN(wr),
      .SFR_WDATA_IN(wdata), .SFR_RDATA_OUT(rdata), .PIN_IN(lvl), .PIN_OUT(pout),
      .PIN_OE_OUT(poe), .PIN_DRIVE_HIGH_OUT(drv), .PIN_ANALOG_OUT(ana), .PERIPH_DATA_IN(pd),
      .PERIPH_OE_IN(pde), .PERIPH_PIN_LEVEL_OUT(plvl), .PERIPH_ROUTED_OUT(routed),
      .PORT_MISMATCH_OUT(miss));
   pio_pin_model u_pins (.pin_out_in(pout), .pin_oe_in(poe), .ext_en_in(ext_en),
      .ext_val_in(ext_val), .pin_level_out(lvl));
   // --------------------------------------------------------------------------
   // Bus and timing helpers
   // --------------------------------------------------------------------------
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wr <= 1'b1;
      wdata <= d;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge sys_clk);
      @(negedge sys_clk);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge sys_clk);
      addr <= a;
      settle(1);
      `CHECK(rdata, exp)
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // --------------------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------------------
   task automatic t_regs;
      rd_chk(8'hF4, 8'h00);
      `CHECK(drv, 24'h00_0000)
      rd_chk(8'hFA, 8'h00);
      rd_chk(8'hF2, 8'hFF);
      wr_reg(8'hF4, 8'hA5);
      rd_chk(8'hF4, 8'hA5);
      wr_reg(8'h00, 8'h5A);
      rd_chk(8'h00, 8'h00);
      $display("test regs done");
   endtask
   task automatic t_latch;
      @(posedge sys_clk);
      ext_en <= 24'hFF_FFFF;
      ext_val <= 24'h3C_A5_96;
      addr <= 8'h80;
      settle(8);
      rd_chk(8'h80, 8'h96);
      rd_chk(8'h90, 8'hA5);
      rd_chk(8'hA0, 8'h3C);
      $display("test latch done");
   endtask
   task automatic t_match;
      wr_reg(8'hD7, 8'h96);
      wr_reg(8'hF4, 8'hFF);
      settle(6);
      `CHECK(miss, 1'b0)
      @(posedge sys_clk);
      ext_val <= 24'h3C_A5_97;
      settle(6);
      `CHECK(miss, 1'b1)
      wr_reg(8'hF4, 8'hFE);
      settle(3);
      `CHECK(miss, 1'b0)
      wr_reg(8'hD9, 8'h01);
      settle(3);
      `CHECK(miss, 1'b1)
      wr_reg(8'hD8, 8'hA5);
      settle(3);
      `CHECK(miss, 1'b0)
      rd_chk(8'hD8, 8'hA5);
      wr_reg(8'hD8, 8'h00);
      settle(3);
      `CHECK(miss, 1'b1)
      wr_reg(8'hD9, 8'h00);
      settle(3);
      `CHECK(miss, 1'b0)
      $display("test match done");
   endtask
   task automatic t_xbar;
      @(posedge sys_clk);
      ext_en <= 24'h00_0000;
      pd <= 16'h0002;
      pde <= 16'h0103;
      wr_reg(8'hF1, 8'hFE);
      wr_reg(8'hD4, 8'h01);
      wr_reg(8'hE1, 8'h03);
      wr_reg(8'hE2, 8'h01);
      settle(3);
      `CHECK(routed, 16'h0103)
      `CHECK(poe[2:0], 3'b010)
      `CHECK(ana[0], 1'b1)
      wr_reg(8'hA4, 8'h06);
      wr_reg(8'hF9, 8'h04);
      wr_reg(8'hFB, 8'h80);
      settle(6);
      `CHECK(pout[2:1], 2'b10)
      `CHECK(drv, 24'h80_0004)
      `CHECK(plvl[1:0], 2'b10)
      wr_reg(8'hD4, 8'hFF);
      wr_reg(8'hD5, 8'hFF);
      wr_reg(8'hD6, 8'hFF);
      settle(3);
      `CHECK(routed, 16'h0000)
      $display("test crossbar done");
   endtask
   initial begin
      repeat (5) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_regs();
      t_latch();
      t_match();
      t_xbar();
      tally_and_finish();
   end
endmodule
`default_nettype wire
